// *** rtl/lcdso_pkg.sv ***
package lcdso_pkg;
  localparam int NUM_SEG = 60;
  localparam int LATCH_BITS = 2 * NUM_SEG;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 1;
  localparam logic [LATCH_BITS-1:0] LATCH_RST = '0;
  // Common reference half period in system cycles; dynamic phases alternate every two halves
  localparam int COM_PERIOD_CYC = 64;
  localparam int COM_CNT_W = 7;

  typedef struct packed {
    logic data;
    logic clk;
    logic load;
  } lcdso_link_s;

  typedef enum logic [0:0] {
    LCDSO_PH_FIRST = 1'b0,
    LCDSO_PH_SECOND = 1'b1
  } lcdso_phase_e;

  typedef struct packed {
    logic com_ref;
    logic com_first_sel;
    logic com_second_sel;
  } lcdso_com_s;
endpackage : lcdso_pkg

// *** rtl/lcdso_fifo.sv ***
module lcdso_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic IN_VALID,
  output logic IN_READY,
  input wire logic [WIDTH-1:0] IN_DATA,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic [WIDTH-1:0] OUT_DATA
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } lcdso_fifo_st_s;
  lcdso_fifo_st_s st_ff, nxt_st;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic do_wr, do_rd;

  assign IN_READY = (st_ff.cnt != (AW+1)'(DEPTH));
  assign OUT_VALID = (st_ff.cnt != '0);
  assign OUT_DATA = mem_ff[st_ff.rp];
  assign do_wr = IN_VALID && IN_READY;
  assign do_rd = OUT_VALID && OUT_READY;

  always_comb begin
    nxt_st = st_ff;
    if (do_wr) begin
      nxt_st.wp = st_ff.wp + 1'b1;
    end
    if (do_rd) begin
      nxt_st.rp = st_ff.rp + 1'b1;
    end
    if (do_wr && !do_rd) begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end else if (do_rd && !do_wr) begin
      nxt_st.cnt = st_ff.cnt - 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (do_wr) begin
      mem_ff[st_ff.wp] <= IN_DATA;
    end
  end
endmodule : lcdso_fifo

// *** rtl/lcdso_top.sv ***
// Behaviour
// RULE1 - Static: segment n from first-half bit n
// RULE2 - Static: second half ignored
// RULE3 - Static on: segment is inverted common reference
// RULE4 - Static off: segment equals common reference
// RULE5 - Dynamic first selected: use first half
// RULE6 - Dynamic second selected: use second half
// RULE7 - Dynamic on: invert selected common signal
// RULE8 - Dynamic off: follow selected common signal
// RULE9 - Oscillator input high inverts output logic
// RULE10 - Shift one bit per shift-clock rise
// RULE11 - Load high copies shift register to latch
// RULE12 - Host sends highest segment first
// RULE13 - Bits 1-60 first half, 61-120 second
// RULE14 - Dynamic phases alternate, one selected
module lcdso_top
  import lcdso_pkg::*;
#(
  parameter int NSEG = NUM_SEG,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int COM_CYC = COM_PERIOD_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire lcdso_pkg::lcdso_link_s LINK_IN,
  input wire logic DYNAMIC_MODE,
  input wire logic OSCILLATOR_INPUT,
  output logic FIFO_OVERRUN,
  output logic [NSEG-1:0] SEGMENT_OUTPUTS,
  output lcdso_pkg::lcdso_com_s COMMON_PHASE_REFERENCE
);
  import lcdso_pkg::*;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [3:0] mode_s1;
    logic [3:0] mode_s2;
    logic clk_prev;
    logic [2*NSEG-1:0] shreg;
    logic [2*NSEG-1:0] latch;
    logic [COM_CNT_W-1:0] com_cnt;
    logic com_ref;
    lcdso_phase_e phase;
    logic overrun;
    logic [NSEG-1:0] seg;
  } lcdso_st_s;

  lcdso_st_s st_ff, nxt_st;
  logic fifo_in_ready, fifo_out_valid;
  logic [0:0] fifo_out_data;
  logic clk_rise;
  logic [NSEG-1:0] sel_bits;
  logic sel_ref;

  // Out of phase when on, in phase when off; osc input flips the sense
  function automatic logic [NSEG-1:0] seg_drive(
    input logic [NSEG-1:0] bits,
    input logic ref_lvl,
    input logic inv
  );
    return bits ^ {NSEG{ref_lvl ^ inv}};
  endfunction : seg_drive

  assign clk_rise = st_ff.s2[1] && !st_ff.clk_prev;

  // Bit stream buffered so a load in flight waits for all shifted bits
  lcdso_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(DEPTH)
  ) u_fifo (
    .CLK_SYS(CLK_SYS),
    .RSTN(RSTN),
    .IN_VALID(clk_rise),
    .IN_READY(fifo_in_ready),
    .IN_DATA(st_ff.s2[2]),
    .OUT_VALID(fifo_out_valid),
    .OUT_READY(1'b1),
    .OUT_DATA(fifo_out_data)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = {LINK_IN.data, LINK_IN.clk, LINK_IN.load};
    nxt_st.s2 = st_ff.s1;
    nxt_st.mode_s1 = {2'b00, DYNAMIC_MODE, OSCILLATOR_INPUT};
    nxt_st.mode_s2 = st_ff.mode_s1;
    nxt_st.clk_prev = st_ff.s2[1];
    if (clk_rise && !fifo_in_ready) begin
      nxt_st.overrun = 1'b1;
    end
    if (fifo_out_valid) begin
      // Highest segment arrives first, ends up at the top [RULE10] [RULE12]
      nxt_st.shreg = {st_ff.shreg[2*NSEG-2:0], fifo_out_data};
    end
    if (st_ff.s2[0] && !fifo_out_valid) begin
      nxt_st.latch = st_ff.shreg; // [RULE11]
    end
    if (st_ff.com_cnt == COM_CNT_W'(COM_CYC - 1)) begin
      nxt_st.com_cnt = '0;
      nxt_st.com_ref = !st_ff.com_ref;
      if (st_ff.com_ref) begin
        // One frame of both polarities per phase [RULE14]
        nxt_st.phase = (st_ff.phase == LCDSO_PH_FIRST) ?
                       LCDSO_PH_SECOND : LCDSO_PH_FIRST;
      end
    end else begin
      nxt_st.com_cnt = st_ff.com_cnt + 1'b1;
    end
    if (!st_ff.mode_s2[1] || st_ff.phase == LCDSO_PH_FIRST) begin
      sel_bits = st_ff.latch[NSEG-1:0]; // [RULE1] [RULE2] [RULE5] [RULE13]
    end else begin
      sel_bits = st_ff.latch[2*NSEG-1:NSEG]; // [RULE6] [RULE13]
    end
    sel_ref = st_ff.com_ref;
    // On: out of phase, off: in phase [RULE3] [RULE4] [RULE7] [RULE8]
    nxt_st.seg = seg_drive(sel_bits, sel_ref, 1'b0);
    if (st_ff.mode_s2[0]) begin
      nxt_st.seg = seg_drive(sel_bits, sel_ref, 1'b1); // [RULE9]
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign SEGMENT_OUTPUTS = st_ff.seg;
  assign FIFO_OVERRUN = st_ff.overrun;
  assign COMMON_PHASE_REFERENCE.com_ref = st_ff.com_ref;
  // Static: both commons selected [RULE14]
  assign COMMON_PHASE_REFERENCE.com_first_sel = !st_ff.mode_s2[1] ||
                                 st_ff.phase == LCDSO_PH_FIRST;
  assign COMMON_PHASE_REFERENCE.com_second_sel = !st_ff.mode_s2[1] ||
                                  st_ff.phase == LCDSO_PH_SECOND;
endmodule : lcdso_top

// *** dv/lcdso_asserts.sv ***
module lcdso_asserts #(
  parameter int NSEG = 60,
  parameter int COM_CYC = 64
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire lcdso_pkg::lcdso_link_s LINK_IN,
  input wire logic DYNAMIC_MODE,
  input wire logic OSCILLATOR_INPUT,
  input wire logic FIFO_OVERRUN,
  input wire logic [NSEG-1:0] SEGMENT_OUTPUTS,
  input wire lcdso_pkg::lcdso_com_s COMMON_PHASE_REFERENCE
);
  import lcdso_pkg::*;
  logic r, f, s;
  logic [2:0] q_ff;
  assign {r, f, s} = COMMON_PHASE_REFERENCE;
  // Latch and syncs settle in under 7 cycles after load, mode or osc moves
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) q_ff <= 3'h0;
    else if (LINK_IN.load || $changed({OSCILLATOR_INPUT, DYNAMIC_MODE}))
      q_ff <= 3'h0;
    else if (q_ff != 3'h7) q_ff <= q_ff + 3'h1;
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  sequence ref_turn;
    $changed(r);
  endsequence
  a_sel_never_idle: assert property (f || s)
    else $error("no common selected");
  a_sel_swap_pair: assert property ((f ^ s) && $changed(f) |-> $changed(s))
    else $error("selects not swapped together");
  a_phase_on_fall: assert property ($fell(r) && (f ^ s) && $past(f ^ s)
    |-> ##[0:1] $changed(f)) else $error("phase kept after ref fall");
  a_ref_half_len: assert property ($rose(r) |-> ##[COM_CYC:COM_CYC] $fell(r))
    else $error("ref half period wrong");
  a_static_flip: assert property ((q_ff == 3'h7 && f && s) ##0 ref_turn
    |=> SEGMENT_OUTPUTS == ~$past(SEGMENT_OUTPUTS)) else $error("no flip");
  a_seg_hold: assert property (q_ff == 3'h7 && $stable(COMMON_PHASE_REFERENCE)
    |=> $stable(SEGMENT_OUTPUTS)) else $error("segments moved");
  a_no_overrun: assert property (!FIFO_OVERRUN)
    else $error("shift edge lost");
  a_overrun_stays: assert property (FIFO_OVERRUN |=> FIFO_OVERRUN)
    else $error("overrun cleared");
endmodule : lcdso_asserts
bind lcdso_top lcdso_asserts #(.NSEG(NSEG), .COM_CYC(COM_CYC)) u_lcdso_asserts (.*);

// *** dv/lcdso_host.sv ***
module lcdso_host (
  output lcdso_pkg::lcdso_link_s link
);
  timeunit 1ns;
  timeprecision 1ns;
  initial link = '0;
  task automatic send(input logic [119:0] fr);
    for (int i = 119; i >= 0; i--) begin
      link.data = fr[i];
      #80 link.clk = 1'b1;
      #80 link.clk = 1'b0;
    end
    // Flip idle data so a stale bit never passes for held data
    link.data = ~link.data;
    #150 link.load = 1'b1;
    #150 link.load = 1'b0;
  endtask : send
endmodule : lcdso_host

// *** dv/lcdso_tb_top.sv ***
module lcdso_tb_top;
  import lcdso_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rstn = 1'b0, dyn = 1'b0, osc = 1'b0, ovr;
  logic [NUM_SEG-1:0] seg;
  lcdso_link_s link;
  lcdso_com_s com, com_q;
  logic [119:0] lat;
  logic [31:0] rnd = 32'h0000_0b1d;
  int checks = 0, miscompares = 0, cyc = 0;
  `define CHK(n, e, g) begin checks++; if ((e) !== (g)) begin \
    miscompares++; $display("ERROR %s exp %h got %h", n, e, g); end end
  lcdso_top #(.COM_CYC(4)) u_lcdso_top (.CLK_SYS(clk), .RSTN(rstn),
    .LINK_IN(link), .DYNAMIC_MODE(dyn), .OSCILLATOR_INPUT(osc),
    .FIFO_OVERRUN(ovr), .SEGMENT_OUTPUTS(seg), .COMMON_PHASE_REFERENCE(com));
  lcdso_host u_lcdso_host (.link(link));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction : xs
  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  always #5 clk = ~clk;
  always @(posedge clk) begin
    com_q <= com;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    for (int t = 0; t < 4; t++) begin
      @(posedge clk);
      dyn <= t[1];
      osc <= t[0];
      repeat (4) begin
        rnd = xs(rnd);
        lat = {lat[87:0], rnd};
      end
      u_lcdso_host.send(lat);
      repeat (10) @(posedge clk);
      repeat (40) begin
        @(posedge clk);
        #1 `CHK("seg", (com_q.com_first_sel ? lat[59:0] : lat[119:60]) ^ {NUM_SEG{com_q.com_ref ^ osc}}, seg)
      end
      `CHK("ovr", 1'b0, ovr)
      $display("test %0d done", t);
    end
    results();
  end
endmodule : lcdso_tb_top
